// >>> design/trip_log_pkg.sv
// Shared constants for the trip status and alarm logger.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package trip_log_pkg;
   // Trip word bit positions
   localparam int BIT_OVERSPEED = 0;
   localparam int BIT_MISSING_PULSE = 1;
   localparam int BIT_FIELD_OVERCUR = 2;
   localparam int BIT_HEATSINK = 3;
   localparam int BIT_MOTOR_THERMAL = 4;
   localparam int BIT_ARM_VOLT_EXCESS = 5;
   localparam int BIT_SPEED_SENSE = 6;
   localparam int BIT_ENCODER = 7;
   localparam int BIT_FIELD_FAIL = 8;
   localparam int BIT_THREE_PHASE = 9;
   localparam int BIT_PHASE_LOCK = 10;
   localparam int BIT_LINK_RX = 11;
   localparam int BIT_STALL = 12;
   localparam int BIT_OVERCURRENT = 13;
   localparam int BIT_MISC = 14;
   localparam int BIT_CURRENT_XFMR = 15;
   // Widths and depths
   localparam int TRIP_W = 16;
   localparam int HIST_DEPTH = 10;
   // Reset value and fallback miscellaneous code
   localparam logic [15:0] NO_ALARM = 16'h0000;
   localparam logic [15:0] MISC_GENERIC = 16'h4000;
   // Extended codes of the miscellaneous class
   localparam logic [15:0] EXT_AUTOTUNE_ERR = 16'hf001;
   localparam logic [15:0] EXT_AUTOTUNE_ABORT = 16'hf002;
   localparam logic [15:0] EXT_PRE_READY = 16'hf003;
   localparam logic [15:0] EXT_CONTACTOR_DLY = 16'hf004;
   localparam logic [15:0] EXT_EXTERNAL = 16'hf005;
   localparam logic [15:0] EXT_REMOTE = 16'hf006;
   localparam logic [15:0] EXT_ENABLE_LOW = 16'hf007;
   localparam logic [15:0] EXT_SEQUENCING = 16'hf009;
   localparam logic [15:0] EXT_COMMS_TIMEOUT = 16'hf010;
   localparam logic [15:0] EXT_CONFIG_EN = 16'hf200;
   localparam logic [15:0] EXT_CALIBRATION = 16'hf300;
   localparam logic [15:0] EXT_NO_OP_STATION = 16'hf400;
   localparam logic [15:0] EXT_AUX_SUPPLY = 16'hff03;
   // Register byte offsets
   localparam logic [7:0] OFS_LIVE = 8'h00;
   localparam logic [7:0] OFS_FIRST = 8'h04;
   localparam logic [7:0] OFS_LAST = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_HIST0 = 8'h10;
   localparam logic [7:0] OFS_HIST_END = 8'h34;
   // Control register fields (write one to act)
   localparam int CTRL_CLR_LAST = 0;
   localparam int CTRL_CLR_HIST = 1;
   // Status fields read back at the control offset
   localparam int STAT_HEALTHY = 0;
   localparam int STAT_TRIPPED = 1;
   localparam int STAT_RUN = 2;
endpackage

// >>> design/trip_alarm_status_logger.sv
// Trip status and alarm logger: live word, first fault, last alarm, history.
// Assumes trip inputs and the run input are synchronous levels, the key a pulse,
// and an Avalon-MM master that holds its request until waitrequest is low.
`timescale 1ns/1ps
module trip_alarm_status_logger
   import trip_log_pkg::*;
(
   input wire logic clock, // System clock, 100 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [trip_log_pkg::TRIP_W-1:0] tripIn, // Detector levels
   input wire logic [15:0] miscCode, // Extended code while misc trip active
   input wire logic runCommandInput, // Start/run level
   input wire logic downKey, // Operator down key, one-cycle pulse
   output logic healthyOutput, // High while no trip latched; reset loads it low
   input wire logic [7:0] address, // Avalon byte address
   input wire logic read, // Avalon read request
   input wire logic write, // Avalon write request
   input wire logic [31:0] writedata, // Avalon write data
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest // Avalon stall, low for one answer cycle
);
   import trip_log_pkg::*;

   // Trip state
   logic [15:0] tripPrev_r; // Last cycle's detector levels
   logic [15:0] liveTrip_r; // Live trip word, also the latch
   logic [15:0] firstFault_r; // First-fault word
   logic [15:0] lastAlarm_r; // Last-alarm code
   logic [15:0] hist_r [HIST_DEPTH]; // Index 0 newest
   logic runPrev_r; // Run level one cycle ago
   logic healthy_r; // Registered healthy output
   // Bus state
   logic ack_r; // Answer cycle in progress
   logic wait_r; // Registered waitrequest
   logic [31:0] rdata_r; // Registered read data

   // Validate an extended code; unknown ones fall back to the class bit
   function automatic logic [15:0] misc_report(input logic [15:0] code);
      case (code)
         EXT_AUTOTUNE_ERR, EXT_AUTOTUNE_ABORT, EXT_PRE_READY, EXT_CONTACTOR_DLY,
         EXT_EXTERNAL, EXT_REMOTE, EXT_ENABLE_LOW, EXT_SEQUENCING,
         EXT_COMMS_TIMEOUT: misc_report = code;
         EXT_CONFIG_EN, EXT_CALIBRATION, EXT_NO_OP_STATION,
         EXT_AUX_SUPPLY: misc_report = code;
         default: misc_report = MISC_GENERIC;
      endcase
   endfunction

   // Event decode
   wire [15:0] newTrips = tripIn & ~tripPrev_r; // Rising edges only
   wire anyNew = |newTrips;
   wire startRise = runCommandInput & ~runPrev_r; // Reset action
   // Sum of codes: each detector owns one bit, so OR equals the sum
   wire [15:0] liveSet = liveTrip_r | tripIn; // Latch new trips
   // On start only still-active trips survive; zero when none remain
   wire [15:0] liveNxt = startRise ? tripIn : liveSet;
   // First fault: capture only into an empty word, start clears it
   wire firstEmpty = (firstFault_r == NO_ALARM);
   // A trip rising in the start cycle becomes the new first fault: capture beats clear
   wire [15:0] firstNxt = startRise ? newTrips :
                          (firstEmpty && anyNew) ? newTrips : firstFault_r;
   // Last alarm code, miscellaneous class replaced by its extended code
   wire [15:0] lastCode = newTrips[BIT_MISC] ? misc_report(miscCode) : newTrips;
   // Bus decode
   wire req = read | write;
   wire takeWrite = write & ack_r; // Effective at the edge that sees waitrequest low
   wire ctrlHit = (address == OFS_CTRL);
   wire clrLast = downKey | (takeWrite & ctrlHit & writedata[CTRL_CLR_LAST]);
   wire clrHist = takeWrite & ctrlHit & writedata[CTRL_CLR_HIST];
   wire histHit = (address >= OFS_HIST0) && (address <= OFS_HIST_END)
                  && (address[1:0] == 2'b00);
   wire [7:0] histOfs = address - OFS_HIST0;
   wire [3:0] histIdx = histOfs[5:2];
   wire [15:0] histWord = histHit ? hist_r[histIdx] : NO_ALARM;
   wire [31:0] statWord = {29'h0, runCommandInput, |liveTrip_r, healthy_r};
   wire [31:0] rdNxt = (address == OFS_LIVE) ? {16'h0, liveTrip_r} :
                       (address == OFS_FIRST) ? {16'h0, firstFault_r} :
                       (address == OFS_LAST) ? {16'h0, lastAlarm_r} :
                       ctrlHit ? statWord :
                       histHit ? {16'h0, histWord} : 32'h0000_0000;

   // Edge detectors and live latch
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tripPrev_r <= NO_ALARM;
         runPrev_r <= 1'b0;
         liveTrip_r <= NO_ALARM;
         firstFault_r <= NO_ALARM;
         healthy_r <= 1'b0;
      end else begin
         tripPrev_r <= tripIn;
         runPrev_r <= runCommandInput;
         liveTrip_r <= liveNxt;
         firstFault_r <= firstNxt;
         healthy_r <= ~(|liveNxt);
      end
   end

   // Last alarm: a new event wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lastAlarm_r <= NO_ALARM;
      end else if (anyNew) begin
         lastAlarm_r <= lastCode;
      end else if (clrLast) begin
         lastAlarm_r <= NO_ALARM;
      end
   end

   // History shift register, one stage per entry
   genvar gi;
   generate
      for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_hist
         wire [15:0] histIn; // Value pushed into this entry
         // Entry one takes the event, the rest their younger neighbour
         if (gi == 0) begin : g_head
            assign histIn = newTrips;
         end else begin : g_body
            // A software clear in a push cycle zeroes this entry; oldest falls off the end
            assign histIn = clrHist ? NO_ALARM : hist_r[gi-1];
         end
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               hist_r[gi] <= NO_ALARM;
            end else if (anyNew) begin
               hist_r[gi] <= histIn;
            end else if (clrHist) begin
               hist_r[gi] <= NO_ALARM;
            end
         end
      end
   endgenerate

   // Avalon slave: one wait cycle, then a single answer cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (req && !ack_r) begin
         ack_r <= 1'b1; // Data settle into register now
         wait_r <= 1'b0;
         rdata_r <= read ? rdNxt : 32'h0000_0000;
      end else begin
         ack_r <= 1'b0; // Master releases after this edge
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end
   end

   assign healthyOutput = healthy_r;
   assign readdata = rdata_r;
   assign waitrequest = wait_r;
endmodule

// >>> testbench/trip_log_properties.sv
// Checker on the logger ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module trip_log_properties (
   input wire logic clock, // Clock
   input wire logic rst_n, // Reset
   input wire logic [15:0] tripIn, // Trips
   input wire logic runCommandInput, // Run
   input wire logic healthyOutput, // Healthy
   input wire logic read, // Read
   input wire logic write, // Write
   input wire logic [31:0] readdata, // Data
   input wire logic waitrequest // Stall
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Request seen, then one answer cycle
   sequence s_req; $rose(read | write); endsequence
   sequence s_ans; ##1 !waitrequest ##1 waitrequest; endsequence
   property p_ans; s_req |-> s_ans; endproperty
   a_ans: assert property (p_ans) else $error("bus answer wrong");
   property p_one; !waitrequest |=> waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_idle; waitrequest |-> readdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("data outside answer");
   property p_upper; !waitrequest |-> readdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper data set");
   property p_low; |(tripIn & ~$past(tripIn)) |=> !healthyOutput; endproperty
   a_low: assert property (p_low) else $error("healthy after trip");
   // Depth 3 skips the edges just after reset release
   property p_hold;
      !healthyOutput && $past(rst_n, 3) && !$rose(runCommandInput) |=> !healthyOutput;
   endproperty
   a_hold: assert property (p_hold) else $error("trip not latched");
   property p_heal;
      $rose(healthyOutput) && $past(rst_n, 3) |->
         $past(runCommandInput) && !$past(runCommandInput, 2) && $past(tripIn) == 16'h0;
   endproperty
   a_heal: assert property (p_heal) else $error("healthy without start");
   property p_clean; $rose(runCommandInput) && tripIn == 16'h0 |=> healthyOutput; endproperty
   a_clean: assert property (p_clean) else $error("start did not clear");
endmodule
bind trip_alarm_status_logger trip_log_properties u_trip_log_properties (.clock(clock),
   .rst_n(rst_n), .tripIn(tripIn), .runCommandInput(runCommandInput),
   .healthyOutput(healthyOutput), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest));

// >>> testbench/trip_detector_model.sv
// Detectors, run sequencer and operator key.
// Assumes the bench sets the controls by non-blocking assignment.
`timescale 1ns/1ps
module trip_detector_model (
   input wire logic clock, // Clock
   input wire logic [15:0] setTrips, // Wanted trips
   input wire logic [15:0] setMisc, // Wanted code
   input wire logic setRun, // Wanted run
   input wire logic pressKey, // Key request
   output logic [15:0] tripIn = 16'h0, // Trip levels
   output logic [15:0] miscCode = 16'h0, // Extended code
   output logic runCommandInput = 1'b0, // Run level
   output logic downKey = 1'b0 // Key pulse
);
   // Registered so each change follows an edge
   always_ff @(posedge clock) begin
      tripIn <= setTrips;
      miscCode <= setMisc;
      runCommandInput <= setRun;
      downKey <= pressKey;
   end
endmodule

// >>> testbench/tb_trip_alarm_status_logger.sv
// Self-checking bench for the trip logger.
// Assumes the detector model sits in front of the trip inputs.
`timescale 1ns/1ps
module tb_trip_alarm_status_logger;
   import trip_log_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, setRun = 1'b0, pressKey = 1'b0, read = 1'b0, write = 1'b0;
   logic [15:0] tripIn, miscCode, setTrips = 16'h0, setMisc = 16'h0; // Trip side
   logic runCommandInput, downKey, healthyOutput, waitrequest; // Status
   logic [7:0] address = 8'h0; // Bus address
   logic [31:0] writedata = 32'h0, readdata; // Bus data
   int errors = 0, comparisons = 0; // Tallies
   always #5 clock = ~clock;
   trip_detector_model u_trip_detector_model (.clock(clock), .setTrips(setTrips),
      .setMisc(setMisc), .setRun(setRun), .pressKey(pressKey), .tripIn(tripIn),
      .miscCode(miscCode), .runCommandInput(runCommandInput), .downKey(downKey));
   trip_alarm_status_logger u_trip_alarm_status_logger (.clock(clock), .rst_n(rst_n),
      .tripIn(tripIn), .miscCode(miscCode), .runCommandInput(runCommandInput),
      .downKey(downKey), .healthyOutput(healthyOutput), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   task conclude;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] seen, exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus cycle; a stuck slave ends the run
   task bus(input logic w, input logic [7:0] a, input logic [15:0] d, e);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {16'h0, d};
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      read <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         errors++;
         conclude();
      end
      if (!w) chk(readdata[15:0], e, $sformatf("reg %h", a));
   endtask
   task wt(input int c); repeat (c) @(posedge clock); endtask
   task trips(input logic [15:0] v); setTrips <= v; wt(3); endtask
   task start; setRun <= 1'b0; wt(3); setRun <= 1'b1; wt(3); endtask
   task t_reset;
      for (int a = 0; a <= 'h40; a += 4) bus(0, a[7:0], 0, a == 'h0c ? 16'h1 : 16'h0);
   endtask
   task t_bits;
      for (int i = 0; i < 16; i++) begin
         trips(16'h1 << i);
         bus(0, OFS_LIVE, 0, 16'h1 << i);
         chk({15'h0, healthyOutput}, 16'h0, "healthy");
         trips(16'h0);
         start();
         bus(0, OFS_LIVE, 0, 16'h0);
      end
      for (int k = 1; k <= 10; k++) bus(0, OFS_HIST0 + 8'(4*(k-1)), 0, 16'h1 << (16-k));
      bus(0, OFS_LAST, 0, 16'h8000);
   endtask
   task t_multi;
      trips(16'h01a8);
      trips(16'h01aa);
      bus(0, OFS_LIVE, 0, 16'h01aa);
      bus(0, OFS_FIRST, 0, 16'h01a8);
      bus(0, OFS_HIST0 + 8'h04, 0, 16'h01a8);
      trips(16'h0008);
      bus(0, OFS_LIVE, 0, 16'h01aa);
      start();
      bus(0, OFS_LIVE, 0, 16'h0008);
      bus(0, OFS_FIRST, 0, 16'h0);
      bus(0, OFS_HIST0, 0, 16'h0002);
      trips(16'h0);
      start();
   endtask
   task t_ext;
      logic [15:0] codes [13] = '{EXT_AUTOTUNE_ERR, EXT_AUTOTUNE_ABORT, EXT_PRE_READY,
         EXT_CONTACTOR_DLY, EXT_EXTERNAL, EXT_REMOTE, EXT_ENABLE_LOW, EXT_SEQUENCING,
         EXT_COMMS_TIMEOUT, EXT_CONFIG_EN, EXT_CALIBRATION, EXT_NO_OP_STATION, EXT_AUX_SUPPLY};
      foreach (codes[j]) begin
         setMisc <= codes[j];
         trips(16'h4000);
         bus(0, OFS_LAST, 0, codes[j]);
         trips(16'h0);
      end
      pressKey <= 1'b1;
      wt(1);
      pressKey <= 1'b0;
      wt(3);
      bus(0, OFS_LAST, 0, NO_ALARM);
      bus(1, OFS_FIRST, 16'hffff, 0);
      bus(0, OFS_FIRST, 0, 16'h4000);
   endtask
   // Status word, software clears and a reset in mid-run
   task t_ctrl;
      bus(0, OFS_CTRL, 0, 16'h0006);
      trips(16'h0008);
      bus(0, OFS_LAST, 0, 16'h0008);
      bus(1, OFS_CTRL, 16'h0002, 0);
      bus(0, OFS_HIST0, 0, NO_ALARM);
      bus(0, OFS_LAST, 0, 16'h0008);
      bus(1, OFS_CTRL, 16'h0001, 0);
      bus(0, OFS_LAST, 0, NO_ALARM);
      trips(16'h0);
      rst_n <= 1'b0;
      wt(6);
      rst_n <= 1'b1;
      bus(0, OFS_LIVE, 0, NO_ALARM);
      bus(0, OFS_FIRST, 0, NO_ALARM);
      bus(0, OFS_CTRL, 0, 16'h0005);
   endtask
   initial begin
      wt(6);
      rst_n <= 1'b1;
      t_reset();
      t_bits();
      t_multi();
      t_ext();
      t_ctrl();
      conclude();
   end
   initial begin
      #200000;
      errors++;
      conclude();
   end
endmodule
